// [core/fwp_ctrl_top.sv]
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// RULE_01: lock bits 00: status write accepted whenever write enable latch set.
// RULE_02: lock bits 01 with protect pin low: every status write refused.
// RULE_03: lock bits 01 with protect pin high: status write needs latch set.
// RULE_04: lock bits 10: status writes blocked until next power cycle.
// RULE_05: power cycle turns lock bits 10 into 00.
// RULE_06: lock bits 11: status writes refused forever.
// RULE_07: size code without complement picks none, top or bottom region.
// RULE_08: complement select protects exactly the inverse region.
// RULE_09: program or erase touching any protected byte is ignored.
// RULE_10: lock bits leave the factory cleared, software protected.
// RULE_11: latch clear rejects status writes, programs and erases.
// RULE_12: size code changes only outside hardware protected mode.
// RULE_13: chip erase only with code 000 uncomplemented or 111 complemented.
// RULE_14: protection fields are kept across power cycles.
// RULE_15: refused status write changes nothing and starts no write cycle.
`include "fwp_defs.svh"
module fwp_ctrl_top
  import fwp_pkg::*;
#(
  parameter int BUSY_CYCLES = `FWP_BUSY_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wp_n,
  input  wire logic        power_up_evt,
  output logic             array_go,
  output logic [3:0]       array_op,
  output logic [18:0]      array_addr,
  output logic             sr_commit,
  output logic             busy
);
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_chk
    $error("BUSY_CYCLES must lie in 1..255");
  end

  logic        dph_wr_ff;
  logic [11:0] dph_addr_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;
  logic [7:0]  srdata_ff;
  logic [18:0] tgt_addr_ff;
  logic        wel_ff;
  fwp_state_t  state_ff;
  fwp_state_t  nxt_state;
  logic [7:0]  cnt_ff;
  fwp_res_t    res_ff;
  fwp_res_t    nxt_res;
  fwp_cmd_t    last_cmd_ff;
  logic [7:0]  refused_ff;
  logic        array_go_ff;
  logic [3:0]  array_op_ff;
  logic [18:0] array_addr_ff;
  logic        sr_commit_ff;
  logic        busy_ff;

  logic        addr_ok;
  logic        wr_cmd;
  logic        wr_srdata;
  logic        wr_addr;
  fwp_cmd_t    cmd;
  logic        accept_sr;
  logic        accept_arr;
  logic        set_wel;
  logic        clr_wel;
  logic [7:0]  sr_q;
  logic        prot_none;
  logic [19:0] prot_lo;
  logic [19:0] prot_hi;
  logic [19:0] op_len_w;
  logic [19:0] op_start;
  logic [19:0] op_end;
  logic        hits;
  logic        chip_ok;
  logic        nv_wr;

  // status write gate from lock bits, pin and latch
  function automatic logic sr_write_ok(input logic [7:0] sr,
                                       input logic pin_n,
                                       input logic write_enable_latch);
    case ({sr[`FWP_LHI_BIT], sr[`FWP_LLO_BIT]})
      2'b00:   sr_write_ok = write_enable_latch; // RULE_01
      2'b01:   sr_write_ok = write_enable_latch & pin_n; // RULE_02 RULE_03
      2'b10:   sr_write_ok = 1'b0; // RULE_04
      2'b11:   sr_write_ok = 1'b0; // RULE_06
      default: sr_write_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [19:0] op_len(input fwp_cmd_t c);
    case (c)
      FWP_CMD_BE4K:  op_len = `FWP_SZ_4K;
      FWP_CMD_BE32K: op_len = `FWP_SZ_32K;
      FWP_CMD_BE64K: op_len = `FWP_SZ_64K;
      FWP_CMD_CHIP:  op_len = `FWP_ARRAY_BYTES;
      default:       op_len = `FWP_PAGE_BYTES;
    endcase
  endfunction

  fwp_nv_store u_nv (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .wr_go        (nv_wr),
    .wr_data      (srdata_ff),
    .power_up_evt (power_up_evt),
    .sr_ff        (sr_q)
  );

  fwp_range_decode u_dec (
    .prot_size (sr_q[`FWP_PS_MSB:`FWP_PS_LSB]),
    .comp_sel  (sr_q[`FWP_CMP_BIT]),
    .prot_none (prot_none),
    .prot_lo   (prot_lo),
    .prot_hi   (prot_hi)
  );

  // read data word for a given register offset
  function automatic logic [31:0] rd_word(input logic [11:0] a);
    rd_word = 32'h00000000;
    case (a)
      `FWP_OFF_CMD:     rd_word[3:0] = last_cmd_ff;
      `FWP_OFF_SRDATA:  rd_word[7:0] = sr_q;
      `FWP_OFF_ADDR:    rd_word[18:0] = tgt_addr_ff;
      `FWP_OFF_STATUS: begin
        rd_word[`FWP_ST_BUSY_BIT] = busy_ff;
        rd_word[`FWP_ST_WEL_BIT] = wel_ff;
        rd_word[`FWP_ST_WP_BIT] = wp_n;
        rd_word[`FWP_ST_LOCK_BIT] = !sr_write_ok(sr_q, wp_n, 1'b1);
        rd_word[`FWP_ST_RES_MSB:`FWP_ST_RES_LSB] = res_ff;
      end
      `FWP_OFF_PROT_LO: rd_word = {prot_none, 11'h000, prot_lo};
      `FWP_OFF_PROT_HI: rd_word = {prot_none, 11'h000, prot_hi};
      `FWP_OFF_REFUSED: rd_word[7:0] = refused_ff;
      default:          rd_word = 32'h00000000;
    endcase
  endfunction

  assign addr_ok = hsel & hready & htrans[1];

  // zero wait state slave; read data sampled at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff   <= 1'b0;
      dph_addr_ff <= 12'h000;
    end else begin
      // only whole-word writes reach the registers
      dph_wr_ff   <= addr_ok & hwrite & (hsize == 3'h2);
      dph_addr_ff <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata_ff <= rd_word(haddr[11:0]);
    end else begin
      hrdata_ff <= 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  assign wr_cmd    = dph_wr_ff && (dph_addr_ff == `FWP_OFF_CMD);
  assign wr_srdata = dph_wr_ff && (dph_addr_ff == `FWP_OFF_SRDATA);
  assign wr_addr   = dph_wr_ff && (dph_addr_ff == `FWP_OFF_ADDR);
  assign cmd       = fwp_cmd_t'(hwdata[3:0]);

  // staged status value, committed only by an accepted status write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srdata_ff <= `FWP_SR_RST;
    end else if (wr_srdata) begin
      srdata_ff <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_addr_ff <= 19'h00000;
    end else if (wr_addr) begin
      tgt_addr_ff <= hwdata[18:0];
    end
  end

  // target region, aligned down to the operation size
  assign op_len_w = op_len(cmd);
  assign op_start = {1'b0, tgt_addr_ff} & ~(op_len_w - 20'h1);
  assign op_end   = op_start + op_len_w - 20'h1;
  assign hits     = !prot_none && (op_start <= prot_hi)
                    && (op_end >= prot_lo); // RULE_09
  assign chip_ok  = (sr_q[2:0] == 3'h0 && !sr_q[`FWP_CMP_BIT])
                 || (sr_q[2:0] == 3'h7 && sr_q[`FWP_CMP_BIT]); // RULE_13

  always_comb begin
    nxt_res    = res_ff;
    accept_sr  = 1'b0;
    accept_arr = 1'b0;
    set_wel    = 1'b0;
    clr_wel    = 1'b0;
    if (wr_cmd) begin
      if (state_ff == FWP_ST_BUSY) begin
        nxt_res = FWP_RES_BUSY;
      end else begin
        case (cmd)
          FWP_CMD_WREN: begin
            set_wel = 1'b1;
            nxt_res = FWP_RES_DONE;
          end
          FWP_CMD_WRDI: begin
            clr_wel = 1'b1;
            nxt_res = FWP_RES_DONE;
          end
          FWP_CMD_WRSR: begin
            if (!wel_ff) begin
              nxt_res = FWP_RES_NO_WEL; // RULE_11
            end else if (!sr_write_ok(sr_q, wp_n, wel_ff)) begin
              // hardware protected mode also freezes the size code
              nxt_res = FWP_RES_LOCKED; // RULE_12 RULE_15
            end else begin
              accept_sr = 1'b1;
              nxt_res   = FWP_RES_DONE;
            end
          end
          FWP_CMD_PROG, FWP_CMD_PERASE, FWP_CMD_BE4K,
          FWP_CMD_BE32K, FWP_CMD_BE64K: begin
            if (!wel_ff) begin
              nxt_res = FWP_RES_NO_WEL; // RULE_11
            end else if (hits) begin
              nxt_res = FWP_RES_PROT; // RULE_09
            end else begin
              accept_arr = 1'b1;
              nxt_res    = FWP_RES_DONE;
            end
          end
          FWP_CMD_CHIP: begin
            if (!wel_ff) begin
              nxt_res = FWP_RES_NO_WEL; // RULE_11
            end else if (!chip_ok) begin
              nxt_res = FWP_RES_PROT; // RULE_13
            end else begin
              accept_arr = 1'b1;
              nxt_res    = FWP_RES_DONE;
            end
          end
          default: nxt_res = FWP_RES_BADCMD;
        endcase
      end
    end
  end

  // a power cycle cuts an internal write short
  assign nv_wr = accept_sr && !power_up_evt; // RULE_15

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wel_ff <= 1'b0;
    end else if (power_up_evt) begin
      wel_ff <= 1'b0;
    end else if (set_wel) begin
      wel_ff <= 1'b1;
    end else if (clr_wel || accept_sr || accept_arr) begin
      wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_ff      <= FWP_RES_NONE;
      last_cmd_ff <= FWP_CMD_NOP;
    end else if (wr_cmd) begin
      res_ff      <= nxt_res;
      last_cmd_ff <= cmd;
    end
  end

  // saturating count of refused commands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refused_ff <= 8'h00;
    end else if (wr_cmd && nxt_res != FWP_RES_DONE
                 && refused_ff != 8'hFF) begin
      refused_ff <= refused_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FWP_ST_IDLE: begin
        if ((accept_sr || accept_arr) && !power_up_evt) begin
          nxt_state = FWP_ST_BUSY;
        end
      end
      FWP_ST_BUSY: begin
        if (power_up_evt || cnt_ff == 8'h00) begin
          nxt_state = FWP_ST_IDLE;
        end
      end
      default: nxt_state = FWP_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= FWP_ST_IDLE;
      cnt_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == FWP_ST_IDLE) begin
        cnt_ff <= 8'(BUSY_CYCLES - 1);
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_go_ff   <= 1'b0;
      array_op_ff   <= 4'h0;
      array_addr_ff <= 19'h00000;
      sr_commit_ff  <= 1'b0;
      busy_ff       <= 1'b0;
    end else begin
      array_go_ff  <= accept_arr && !power_up_evt; // RULE_09
      sr_commit_ff <= nv_wr; // RULE_15
      busy_ff      <= (nxt_state == FWP_ST_BUSY);
      if (accept_arr) begin
        array_op_ff   <= cmd;
        array_addr_ff <= op_start[18:0];
      end
    end
  end

  assign hrdata     = hrdata_ff;
  assign hreadyout  = hreadyout_ff;
  assign hresp      = hresp_ff;
  assign array_go   = array_go_ff;
  assign array_op   = array_op_ff;
  assign array_addr = array_addr_ff;
  assign sr_commit  = sr_commit_ff;
  assign busy       = busy_ff;
endmodule

// [core/fwp_defs.svh]
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH
// register byte offsets, decoded on haddr[11:0]
`define FWP_OFF_CMD      12'h000
`define FWP_OFF_SRDATA   12'h004
`define FWP_OFF_ADDR     12'h008
`define FWP_OFF_STATUS   12'h00C
`define FWP_OFF_PROT_LO  12'h010
`define FWP_OFF_PROT_HI  12'h014
`define FWP_OFF_REFUSED  12'h018
// protection byte layout
`define FWP_PS_LSB       0
`define FWP_PS_MSB       4
`define FWP_CMP_BIT      5
`define FWP_LLO_BIT      6
`define FWP_LHI_BIT      7
// status register layout
`define FWP_ST_BUSY_BIT  0
`define FWP_ST_WEL_BIT   1
`define FWP_ST_WP_BIT    2
`define FWP_ST_LOCK_BIT  3
`define FWP_ST_RES_LSB   4
`define FWP_ST_RES_MSB   6
// factory state: all fields clear, software protected
`define FWP_SR_RST       8'h00
// internal write cycle length in clock cycles
`define FWP_BUSY_CYCLES  16
// array geometry in bytes
`define FWP_ARRAY_BYTES  20'h80000
`define FWP_SZ_4K        20'h01000
`define FWP_SZ_32K       20'h08000
`define FWP_SZ_64K       20'h10000
`define FWP_PAGE_BYTES   20'h00100
`endif

// [core/fwp_pkg.sv]
package fwp_pkg;
  typedef enum logic [3:0] {
    FWP_CMD_NOP,
    FWP_CMD_WREN,
    FWP_CMD_WRDI,
    FWP_CMD_WRSR,
    FWP_CMD_PROG,
    FWP_CMD_PERASE,
    FWP_CMD_BE4K,
    FWP_CMD_BE32K,
    FWP_CMD_BE64K,
    FWP_CMD_CHIP
  } fwp_cmd_t;
  typedef enum logic [2:0] {
    FWP_RES_NONE,
    FWP_RES_DONE,
    FWP_RES_NO_WEL,
    FWP_RES_LOCKED,
    FWP_RES_PROT,
    FWP_RES_BUSY,
    FWP_RES_BADCMD
  } fwp_res_t;
  typedef enum logic {
    FWP_ST_IDLE,
    FWP_ST_BUSY
  } fwp_state_t;
endpackage

// [core/fwp_range_decode.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_range_decode
  import fwp_pkg::*;
(
  input  wire logic [4:0]  prot_size,
  input  wire logic        comp_sel,
  output logic             prot_none,
  output logic [19:0]      prot_lo,
  output logic [19:0]      prot_hi
);
  logic [19:0] sz;
  logic        all;
  logic [19:0] cut;

  always_comb begin
    sz  = 20'h00000;
    all = 1'b0;
    if (prot_size[2:0] == 3'h0) begin
      sz = 20'h00000; // RULE_07
    end else if (!prot_size[4]) begin
      if (prot_size[2]) begin
        all = 1'b1; // RULE_07
      end else begin
        sz = `FWP_SZ_64K << 2'(prot_size[1:0] - 2'h1); // RULE_07
      end
    end else if (prot_size[2:0] == 3'h7) begin
      all = 1'b1; // RULE_07
    end else if (prot_size[2]) begin
      sz = `FWP_SZ_32K; // RULE_07
    end else begin
      sz = `FWP_SZ_4K << 2'(prot_size[1:0] - 2'h1); // RULE_07
    end
    cut = prot_size[3] ? sz : (`FWP_ARRAY_BYTES - sz);
    prot_lo = 20'h00000;
    prot_hi = `FWP_ARRAY_BYTES - 20'h1;
    if (all) begin
      prot_none = comp_sel; // RULE_08
    end else if (sz == 20'h00000) begin
      prot_none = !comp_sel; // RULE_08
    end else begin
      prot_none = 1'b0;
      // bottom region, or complement of a top one, sits low
      if (prot_size[3] ^ comp_sel) begin // RULE_07 RULE_08
        prot_hi = cut - 20'h1;
      end else begin
        prot_lo = cut;
      end
    end
  end
endmodule

// [core/fwp_nv_store.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_nv_store
  import fwp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        wr_go,
  input  wire logic [7:0]  wr_data,
  input  wire logic        power_up_evt,
  output logic [7:0]       sr_ff
);
  // hresetn stands for the factory state, not for a power cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_ff <= `FWP_SR_RST; // RULE_10
    end else if (power_up_evt) begin
      if (sr_ff[`FWP_LHI_BIT] && !sr_ff[`FWP_LLO_BIT]) begin
        sr_ff[`FWP_LHI_BIT] <= 1'b0; // RULE_05
      end
    end else if (wr_go) begin
      sr_ff <= wr_data; // RULE_14
    end
  end
endmodule

// [bench/fwp_ctrl_properties.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_ctrl_props
  import fwp_pkg::*;
#(
  parameter int BUSY_CYCLES = 16
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        wp_n,
  input wire logic        power_up_evt,
  input wire logic        array_go,
  input wire logic [3:0]  array_op,
  input wire logic        sr_commit,
  input wire logic        busy
);
  logic       aph_ff;
  logic       sph_ff;
  logic [3:0] req_ff;
  logic [7:0] stg_ff;
  logic [7:0] prot_ff;
  logic       latch_ff;
  logic [8:0] cnt_ff;
  logic       wtake;
  logic       cmd_dp;
  assign wtake  = hsel && htrans[1] && hwrite && hsize == 3'h2;
  assign cmd_dp = aph_ff && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= 1'b0;
      sph_ff <= 1'b0;
    end else if (hready) begin
      aph_ff <= wtake && haddr[11:0] == `FWP_OFF_CMD;
      sph_ff <= wtake && haddr[11:0] == `FWP_OFF_SRDATA;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= 4'h0;
      stg_ff <= 8'h00;
      cnt_ff <= 9'h000;
    end else begin
      req_ff <= cmd_dp ? hwdata[3:0] : 4'h0;
      cnt_ff <= busy ? cnt_ff + 9'h001 : 9'h000;
      if (sph_ff && hready) begin
        stg_ff <= hwdata[7:0];
      end
    end
  end
  // committed byte lags the design by a cycle; harmless while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_ff <= `FWP_SR_RST;
    end else if (power_up_evt && prot_ff[7:6] == 2'h2) begin
      prot_ff[7:6] <= 2'h0;
    end else if (sr_commit) begin
      prot_ff <= stg_ff;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_ff <= 1'b0;
    end else if (power_up_evt || sr_commit || array_go) begin
      latch_ff <= 1'b0;
    end else if (cmd_dp && !busy && hwdata[3:0] == FWP_CMD_WREN) begin
      latch_ff <= 1'b1;
    end else if (cmd_dp && !busy && hwdata[3:0] == FWP_CMD_WRDI) begin
      latch_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence wrsr_s;
    cmd_dp && hwdata[3:0] == FWP_CMD_WRSR;
  endsequence
  sequence start_s;
    busy ##1 (!sr_commit && !array_go);
  endsequence
  commit_ok_a: assert property (wrsr_s ##0 (latch_ff && !busy &&
    !power_up_evt && (!prot_ff[7] && (!prot_ff[6] || wp_n)))
    |=> sr_commit && busy) else $error("accepted status write lost");
  lock_block_a: assert property (wrsr_s ##0 (prot_ff[7] ||
    (prot_ff[6] && !wp_n)) |=> !sr_commit)
    else $error("locked status write started");
  no_latch_a: assert property (cmd_dp && !latch_ff &&
    hwdata[3:0] >= 4'h3 && hwdata[3:0] <= 4'h9
    |=> !sr_commit && !array_go) else $error("command ran without latch");
  commit_cause_a: assert property (sr_commit |->
    req_ff == FWP_CMD_WRSR) else $error("write cycle without request");
  go_cause_a: assert property (array_go |-> req_ff >= 4'h4 &&
    req_ff <= 4'h9 && array_op == req_ff)
    else $error("array start without request");
  start_pulse_a: assert property ((sr_commit || array_go)
    |-> start_s) else $error("start pulse or busy wrong");
  busy_len_a: assert property ($fell(busy) && !$past(power_up_evt)
    |-> cnt_ff == BUSY_CYCLES) else $error("write cycle length wrong");
  chip_gate_a: assert property (array_go && array_op == FWP_CMD_CHIP
    |-> (prot_ff[2:0] == 3'h0 && !prot_ff[5]) ||
    (prot_ff[2:0] == 3'h7 && prot_ff[5])) else $error("chip erase let through");
endmodule
bind fwp_ctrl_top fwp_ctrl_props #(.BUSY_CYCLES(BUSY_CYCLES)) i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .wp_n(wp_n), .power_up_evt(power_up_evt),
  .array_go(array_go), .array_op(array_op), .sr_commit(sr_commit),
  .busy(busy));

// [bench/fwp_host.sv]
`timescale 1ns/1ps
module fwp_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  // waits on hready so a slave with wait states is served too
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output bit ok);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 128);
    q = hrdata;
    ok = n < 128;
    // released data lines must not keep the last word
    hwdata <= ~d;
  endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
module testbench
  import fwp_pkg::*;
;
  localparam int BUSY = 4;
  logic        hclk;
  logic        hresetn;
  logic        wp_n;
  logic        power_up_evt;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        array_go;
  logic [3:0]  array_op;
  logic [18:0] array_addr;
  logic        sr_commit;
  logic        busy;
  int          miscompares;
  int          cmp_count;
  int          go_cnt;
  // byte, nothing flag, lowest and highest protected byte
  logic [48:0] rows [17] = '{
    {8'h00, 1'b1, 20'h00000, 20'h00000},
    {8'h01, 1'b0, 20'h70000, 20'h7FFFF},
    {8'h03, 1'b0, 20'h40000, 20'h7FFFF},
    {8'h09, 1'b0, 20'h00000, 20'h0FFFF},
    {8'h0B, 1'b0, 20'h00000, 20'h3FFFF},
    {8'h04, 1'b0, 20'h00000, 20'h7FFFF},
    {8'h11, 1'b0, 20'h7F000, 20'h7FFFF},
    {8'h14, 1'b0, 20'h78000, 20'h7FFFF},
    {8'h1B, 1'b0, 20'h00000, 20'h03FFF},
    {8'h18, 1'b1, 20'h00000, 20'h00000},
    {8'h20, 1'b0, 20'h00000, 20'h7FFFF},
    {8'h21, 1'b0, 20'h00000, 20'h6FFFF},
    {8'h29, 1'b0, 20'h10000, 20'h7FFFF},
    {8'h24, 1'b1, 20'h00000, 20'h00000},
    {8'h31, 1'b0, 20'h00000, 20'h7EFFF},
    {8'h3E, 1'b0, 20'h08000, 20'h7FFFF},
    {8'h3F, 1'b1, 20'h00000, 20'h00000}};
  fwp_ctrl_top #(.BUSY_CYCLES(BUSY)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wp_n(wp_n), .power_up_evt(power_up_evt),
    .array_go(array_go), .array_op(array_op), .array_addr(array_addr),
    .sr_commit(sr_commit), .busy(busy));
  fwp_host i_host (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (array_go === 1'b1) begin
      go_cnt++;
    end
  end
  task automatic results();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    bit ok;
    i_host.xfer(w, a, d, q, ok);
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: bus wait ran out", $time);
      results();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xf(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    xf(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic res(input fwp_res_t e);
    rdc(`FWP_OFF_STATUS, {25'h0, e, 4'h0}, 32'h0000_0070);
  endtask
  task automatic cmd(input fwp_cmd_t c);
    int n;
    wr(`FWP_OFF_CMD, {28'h0, c});
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 64);
    if (busy !== 1'b0) begin
      miscompares++;
      $display("mismatch at %0t: write cycle never ended", $time);
      results();
    end
  endtask
  task automatic set_sr(input logic [7:0] v);
    wr(`FWP_OFF_SRDATA, {24'h0, v});
    cmd(FWP_CMD_WREN);
    cmd(FWP_CMD_WRSR);
  endtask
  task automatic pwr();
    @(posedge hclk);
    power_up_evt <= 1'b1;
    @(posedge hclk);
    power_up_evt <= 1'b0;
  endtask
  task automatic try_op(input fwp_cmd_t op, input logic [18:0] a,
                        input logic ok);
    int g0;
    g0 = go_cnt;
    cmd(FWP_CMD_WREN);
    wr(`FWP_OFF_ADDR, {13'h0, a});
    cmd(op);
    res(ok ? FWP_RES_DONE : FWP_RES_PROT);
    chk(go_cnt - g0, {31'h0, ok});
    if (ok) begin
      chk({13'h0, array_addr}, {13'h0, a});
      chk({28'h0, array_op}, {28'h0, op});
    end
  endtask
  initial begin
    hresetn = 1'b0;
    wp_n = 1'b1;
    power_up_evt = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`FWP_OFF_SRDATA, 32'h0);
    rdc(`FWP_OFF_STATUS, 32'h4);
    wr(`FWP_OFF_SRDATA, 32'h3F);
    cmd(FWP_CMD_WRSR);
    res(FWP_RES_NO_WEL);
    rdc(`FWP_OFF_SRDATA, 32'h0);
    cmd(FWP_CMD_PROG);
    res(FWP_RES_NO_WEL);
    chk(go_cnt, 32'h0);
    for (int i = 0; i < 17; i++) begin
      set_sr(rows[i][48:41]);
      rdc(`FWP_OFF_SRDATA, {24'h0, rows[i][48:41]});
      rdc(`FWP_OFF_PROT_LO, {rows[i][40], 11'h0, rows[i][39:20]},
          rows[i][40] ? 32'h8000_0000 : 32'h800F_FFFF);
      rdc(`FWP_OFF_PROT_HI, {rows[i][40], 11'h0, rows[i][19:0]},
          rows[i][40] ? 32'h8000_0000 : 32'h800F_FFFF);
    end
    set_sr(8'h01);
    try_op(FWP_CMD_PROG, 19'h70000, 1'b0);
    try_op(FWP_CMD_PROG, 19'h6FF00, 1'b1);
    try_op(FWP_CMD_PERASE, 19'h7FF00, 1'b0);
    try_op(FWP_CMD_BE4K, 19'h6F000, 1'b1);
    try_op(FWP_CMD_BE32K, 19'h68000, 1'b1);
    try_op(FWP_CMD_BE64K, 19'h70000, 1'b0);
    try_op(FWP_CMD_CHIP, 19'h00000, 1'b0);
    set_sr(8'h27);
    try_op(FWP_CMD_CHIP, 19'h00000, 1'b1);
    set_sr(8'h24);
    try_op(FWP_CMD_CHIP, 19'h00000, 1'b0);
    set_sr(8'h41);
    wp_n <= 1'b0;
    set_sr(8'h00);
    res(FWP_RES_LOCKED);
    rdc(`FWP_OFF_SRDATA, 32'h41);
    wp_n <= 1'b1;
    cmd(FWP_CMD_WRSR);
    rdc(`FWP_OFF_SRDATA, 32'h00);
    set_sr(8'h81);
    set_sr(8'h02);
    rdc(`FWP_OFF_SRDATA, 32'h81);
    pwr();
    rdc(`FWP_OFF_SRDATA, 32'h01);
    set_sr(8'hC2);
    pwr();
    set_sr(8'h00);
    rdc(`FWP_OFF_SRDATA, 32'hC2);
    // second command lands while the page program still runs
    cmd(FWP_CMD_WREN);
    wr(`FWP_OFF_CMD, {28'h0, FWP_CMD_PROG});
    cmd(FWP_CMD_WREN);
    rdc(`FWP_OFF_STATUS, 32'h5C);
    chk(go_cnt, 32'h5);
    cmd(fwp_cmd_t'(4'hF));
    res(FWP_RES_BADCMD);
    rdc(`FWP_OFF_CMD, 32'hF);
    rdc(`FWP_OFF_REFUSED, 32'hC);
    chk({31'h0, hresp}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`FWP_OFF_SRDATA, 32'h0);
    results();
  end
endmodule
